// [rtl/adc_port_pkg.sv]
// Constants shared by the pipelined converter output port and its FIFO.
// Assumes a single 200 MHz clock domain and a synchronous active-high reset.
//
// Function
// - With the active-low output enable high, all twelve data lines are released.
// - With the active-low output enable low, the result is driven onto the twelve data lines.
// - With shutdown high, the converter enters shutdown and stops converting.
// - Output line 0 carries the least significant bit and line 11 the most significant.
// - Each sample is resolved by twelve 1.5-bit stages into a twelve-bit word; the code takes 1.5-bit stage decisions of 0, 1 or 2.
// - The word for a sample appears exactly seven sample clocks after the sample.
// - A sample advances one stage every half sample clock, the output latch included.
// - Stage decisions are combined with digital error correction so no code is missing.
// - Results are offset binary, zero input giving only the top bit set.
// - With outputs enabled and shutdown high, the lines hold the last code before shutdown.
// - A sample is taken on the rising edge of the true sample clock.
package adc_port_pkg;
    // =========================================================================
    // Widths and timing.
    // =========================================================================
    localparam int RES_BITS = 12;
    localparam int LATENCY_CYC = 7;
    localparam int HALF_STEPS = 2 * LATENCY_CYC;
    localparam int FIFO_DEPTH = 4;
    localparam logic [11:0] MID_CODE = 12'h800;
    localparam logic [11:0] RESET_WORD = 12'h000;
    localparam int CLK_MAX_KHZ = 60000;
    localparam int CLK_MIN_KHZ = 100;
endpackage

// [rtl/word_fifo.sv]
// Small flip-flop FIFO with valid and ready on both sides.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/100ps
module word_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // Depth must be a power of two so the pointers wrap by overflow.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
    begin : bad_cfg
        $error("word_fifo: DEPTH must be a power of two of at least 2.");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] nxt_mem [DEPTH];
    logic [AW:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic push, pop;

    // =========================================================================
    // Pointer and storage update.
    // =========================================================================
    // Full and empty come from the extra pointer bit, so no count is kept.
    always_comb
    begin
        in_ready = (wr_ff - rd_ff) != (AW + 1)'(DEPTH);
        out_valid = wr_ff != rd_ff;
        out_data = mem_ff[rd_ff[AW-1:0]];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        nxt_mem = mem_ff;
        if (push)
        begin
            nxt_mem[wr_ff[AW-1:0]] = in_data;
        end
        nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
        nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
    end

    // Storage is not reset; only the pointers define what is valid.
    always_ff @(posedge clk)
    begin
        mem_ff <= nxt_mem;
        if (srst)
        begin
            wr_ff <= '0;
            rd_ff <= '0;
        end
        else
        begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
        end
    end
endmodule

// [rtl/adc_output_port.sv]
// Digital side of a twelve-stage pipelined converter: stage pipeline,
// error correction, output latch and three-state data port.
// Assumes MCLK at 200 MHz; the sample clock and controls arrive as pins.
`timescale 1ns/100ps
module adc_output_port #(
    parameter int STAGES = adc_port_pkg::RES_BITS
)
(
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic SAMPLE_CLK,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic SHUTDOWN_REQUEST,
    input wire logic [1:0] STAGE_DECISION [adc_port_pkg::RES_BITS],
    output logic [adc_port_pkg::RES_BITS-1:0] SAMPLE_WORD_O,
    output logic [adc_port_pkg::RES_BITS-1:0] SAMPLE_WORD_OE,
    output logic WORD_STROBE,
    output logic SHUTDOWN_ACTIVE
);
    localparam int N = adc_port_pkg::RES_BITS;
    localparam int HS = adc_port_pkg::HALF_STEPS;

    // The pipeline is built for exactly twelve 1.5-bit stages.
    if (STAGES != N)
    begin : bad_cfg
        $error("adc_output_port: STAGES must equal the result width.");
    end

    // =========================================================================
    // Pin synchronisers.
    // =========================================================================
    // Pin order in the synchroniser words is {enable, shutdown, sample clock}.
    logic [2:0] s1_ff, s2_ff, nxt_s1, nxt_s2;
    logic clk_prev_ff, nxt_clk_prev;
    logic [1:0] dec1_ff [N];
    logic [1:0] dec2_ff [N];
    logic [1:0] nxt_dec1 [N];
    logic [1:0] nxt_dec2 [N];

    // Two flops per pin; only the second stage is looked at by logic.
    // Reset parks both stages at the idle levels (enable released, no
    // shutdown, sample clock low), so neither a false edge nor a false
    // shutdown indication follows the release of reset.
    always_comb
    begin
        nxt_s1 = {OUTPUT_ENABLE_N, SHUTDOWN_REQUEST, SAMPLE_CLK};
        nxt_s2 = s1_ff;
        nxt_clk_prev = s2_ff[0];
        if (SRST)
        begin
            nxt_s1 = 3'h4;
            nxt_s2 = 3'h4;
            nxt_clk_prev = 1'b0;
        end
        // Decisions are read only on a detected edge, when they have been
        // steady for two cycles, so they need no reset of their own.
        nxt_dec1 = STAGE_DECISION;
        nxt_dec2 = dec1_ff;
    end

    // Registers only.
    always_ff @(posedge MCLK)
    begin
        s1_ff <= nxt_s1;
        s2_ff <= nxt_s2;
        clk_prev_ff <= nxt_clk_prev;
        dec1_ff <= nxt_dec1;
        dec2_ff <= nxt_dec2;
    end

    logic clk_s, oe_n_s, shut_s, rise, fall, step;
    assign clk_s = s2_ff[0];
    assign shut_s = s2_ff[1];
    assign oe_n_s = s2_ff[2];
    assign rise = clk_s && !clk_prev_ff;
    assign fall = !clk_s && clk_prev_ff;
    // A half-cycle tick on either sample-clock edge moves the pipeline on.
    assign step = (rise || fall) && !shut_s;

    // =========================================================================
    // Stage pipeline and error correction.
    // =========================================================================
    // Each slot carries the decisions taken so far plus an occupancy flag.
    // Slot k holds a sample that has completed k half-cycle steps.
    logic [1:0] pipe_ff [HS][N];
    logic [1:0] nxt_pipe [HS][N];
    logic [HS-1:0] live_ff, nxt_live;
    logic [N-1:0] word_ff, nxt_word;
    logic strobe_ff, nxt_strobe;
    logic [N-1:0] corrected;

    // Redundant decisions of 0, 1 or 2 are weighted by two per stage and
    // summed; the overlap absorbs comparator offsets so all codes occur.
    always_comb
    begin
        logic [N+1:0] acc;
        acc = '0;
        for (int i = 0; i < N; i++)
        begin
            acc = (N + 2)'({acc, 1'b0}) + (N + 2)'(pipe_ff[HS-1][i]);
        end
        // The 1.5-bit sum is offset by one LSB-weighted half range; remove it
        // so a zero input lands on the mid code.
        acc = acc - (N + 2)'({N{1'b1}}) + (N + 2)'(adc_port_pkg::MID_CODE);
        if (acc[N+1])
        begin
            corrected = '0;
        end
        else if (acc[N])
        begin
            corrected = '1;
        end
        else
        begin
            corrected = acc[N-1:0];
        end
    end

    // A sample enters on the rising edge and leaves 14 half steps later,
    // which is seven sample clocks; shutdown freezes the whole chain.
    always_comb
    begin
        nxt_pipe = pipe_ff;
        nxt_live = live_ff;
        nxt_word = word_ff;
        nxt_strobe = 1'b0;
        if (step)
        begin
            for (int k = HS - 1; k > 0; k--)
            begin
                nxt_pipe[k] = pipe_ff[k-1];
                nxt_live[k] = live_ff[k-1];
            end
            nxt_pipe[0] = dec2_ff;
            nxt_live[0] = rise;
            if (live_ff[HS-1])
            begin
                nxt_word = corrected;
                nxt_strobe = 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            live_ff <= '0;
            word_ff <= adc_port_pkg::RESET_WORD;
            strobe_ff <= 1'b0;
        end
        else
        begin
            live_ff <= nxt_live;
            word_ff <= nxt_word;
            strobe_ff <= nxt_strobe;
        end
        pipe_ff <= nxt_pipe;
    end

    // =========================================================================
    // Output FIFO and three-state port.
    // =========================================================================
    // The FIFO drains only while the bus is enabled and not shut down, so
    // words written during a disabled spell are held, not lost, up to four.
    // A word that finds the FIFO full is dropped: the pipeline cannot be
    // stalled without losing its half-cycle timing, so the oldest words win.
    logic fifo_valid;
    logic [N-1:0] fifo_data;
    logic drain;
    assign drain = !oe_n_s && !shut_s;

    word_fifo #(
        .WIDTH(N),
        .DEPTH(adc_port_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .srst(SRST),
        .in_valid(strobe_ff),
        .in_ready(),
        .in_data(word_ff),
        .out_valid(fifo_valid),
        .out_ready(drain),
        .out_data(fifo_data)
    );

    logic [N-1:0] dout_ff, nxt_dout, oe_ff, nxt_oe;
    logic strb_ff, nxt_strb, shut_ff;

    // Line i carries bit i, so bit 0 is the least significant line.
    always_comb
    begin
        nxt_dout = dout_ff;
        nxt_strb = 1'b0;
        if (drain && fifo_valid)
        begin
            nxt_dout = fifo_data;
            nxt_strb = 1'b1;
        end
        // In shutdown the last code is simply held.
        nxt_oe = oe_n_s ? '0 : '1;
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            dout_ff <= adc_port_pkg::RESET_WORD;
            oe_ff <= '0;
            strb_ff <= 1'b0;
            shut_ff <= 1'b0;
        end
        else
        begin
            dout_ff <= nxt_dout;
            oe_ff <= nxt_oe;
            strb_ff <= nxt_strb;
            shut_ff <= shut_s;
        end
    end

    assign SAMPLE_WORD_O = dout_ff;
    assign SAMPLE_WORD_OE = oe_ff;
    assign WORD_STROBE = strb_ff;
    assign SHUTDOWN_ACTIVE = shut_ff;
endmodule

// [bench/adc_output_port_checker.sv]
// Pin assertions for the converter output port.
// Bound to adc_output_port; a single MCLK domain.
`timescale 1ns/100ps
module adc_output_port_checker (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic SAMPLE_CLK,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic SHUTDOWN_REQUEST,
    input wire logic [11:0] SAMPLE_WORD_O,
    input wire logic [11:0] SAMPLE_WORD_OE,
    input wire logic WORD_STROBE,
    input wire logic SHUTDOWN_ACTIVE
);
    // ==========================================
    // Sample-clock rise counter.
    // ==========================================
    logic clk_ff;
    logic nxt_clk;
    logic [3:0] rise_ff;
    logic [3:0] nxt_rise;
    // Saturates at eight, since the first word needs its sample and seven more.
    always_comb
    begin
        nxt_clk = SAMPLE_CLK & ~SRST;
        nxt_rise = SRST ? 4'h0 : rise_ff + {3'h0, SAMPLE_CLK & ~clk_ff & (rise_ff != 4'h8)};
    end
    // Registers only.
    always_ff @(posedge MCLK)
    begin
        clk_ff <= nxt_clk;
        rise_ff <= nxt_rise;
    end
    // ==========================================
    // Assertions.
    // ==========================================
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);
    a_oe_released: assert property (OUTPUT_ENABLE_N [*5] |-> SAMPLE_WORD_OE == 12'h000)
        else $error("lines driven while disabled");
    a_oe_driving: assert property (!OUTPUT_ENABLE_N [*5] |-> SAMPLE_WORD_OE == 12'hfff)
        else $error("lines released while enabled");
    a_oe_off_quick: assert property ($rose(OUTPUT_ENABLE_N) |->
        ##[1:5] SAMPLE_WORD_OE == 12'h000)
        else $error("late release of lines");
    a_oe_on_quick: assert property ($fell(OUTPUT_ENABLE_N) |->
        ##[1:5] SAMPLE_WORD_OE == 12'hfff)
        else $error("late drive of lines");
    a_shut_follows: assert property ($stable(SHUTDOWN_REQUEST) [*5] |->
        SHUTDOWN_ACTIVE == SHUTDOWN_REQUEST)
        else $error("shutdown state wrong");
    a_shut_holds: assert property (SHUTDOWN_ACTIVE && $past(SHUTDOWN_ACTIVE) |->
        $stable(SAMPLE_WORD_O) && !WORD_STROBE)
        else $error("word moved in shutdown");
    a_word_stands: assert property (!WORD_STROBE |-> $stable(SAMPLE_WORD_O))
        else $error("word changed without strobe");
    a_no_early_word: assert property (WORD_STROBE |-> rise_ff == 4'h8)
        else $error("word before seven periods");
endmodule

// [bench/capture_side_model.sv]
// Capture-side model: makes the sample clock and resolves the data lines.
// Assumes the bench raises run on the falling edge of MCLK.
`timescale 1ns/100ps
module capture_side_model (
    input wire logic MCLK,
    input wire logic run,
    input wire logic [11:0] word_o,
    input wire logic [11:0] word_oe,
    output logic sample_clk,
    output logic [11:0] bus
);
    logic [2:0] phase = 3'h0;
    logic [11:0] last = 12'h000;
    initial sample_clk = 1'b0;
    // Eight MCLK per period is 25 MHz; a started period always completes.
    always @(negedge MCLK)
    begin
        if (run || phase != 3'h0)
        begin
            sample_clk <= phase < 3'h4;
            phase <= phase + 3'h1;
        end
    end
    // A released line toggles, so a stale value can never pass as data.
    assign bus = (word_oe & word_o) | (~word_oe & ~last);
    always @(posedge MCLK)
        last <= bus;
endmodule

// [bench/adc_output_port_tb_top.sv]
// Self-checking bench for the converter output port.
// Assumes package, FIFO, port, checker and capture model compiled first.
`timescale 1ns/100ps
module adc_output_port_tb_top;
    logic MCLK = 1'b0;
    logic SRST = 1'b1;
    logic run = 1'b0;
    logic oe_n = 1'b0;
    logic shut = 1'b0;
    logic sclk, strobe, shut_act;
    logic [1:0] dec [12];
    logic [11:0] word, oe, bus;
    int failures = 0;
    int comparisons = 0;
    int seed = int'(32'hd123c144);
    int pat = 0;
    int cycles = 0;
    int last_exp = 0;
    int pipe_q[$];
    int exp_q[$];
    adc_output_port adc_output_port_i (.MCLK(MCLK), .SRST(SRST), .SAMPLE_CLK(sclk),
        .OUTPUT_ENABLE_N(oe_n), .SHUTDOWN_REQUEST(shut), .STAGE_DECISION(dec),
        .SAMPLE_WORD_O(word), .SAMPLE_WORD_OE(oe), .WORD_STROBE(strobe),
        .SHUTDOWN_ACTIVE(shut_act));
    capture_side_model capture_side_model_i (.MCLK(MCLK), .run(run), .word_o(word),
        .word_oe(oe), .sample_clk(sclk), .bus(bus));
    initial foreach (dec[i]) dec[i] = 2'h1;
    initial forever #2.5 MCLK = ~MCLK;
    // ==========================================
    // Shared tasks.
    // ==========================================
    task automatic cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
        comparisons++;
        if (exp !== got)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Runs whole sample periods, then waits for the last word to settle.
    task automatic periods(input int n);
        run <= 1'b1;
        repeat (8 * n - 1) @(negedge MCLK);
        run <= 1'b0;
        repeat (16) @(negedge MCLK);
    endtask
    // Weighted stage sum, corrected and clamped to twelve bits.
    function automatic int calc();
        int s = 0;
        foreach (dec[i]) s += int'(dec[i]) << (11 - i);
        s = s - 32'shfff + 32'sh800;
        return s < 0 ? 0 : (s > 32'shfff ? 32'shfff : s);
    endfunction
    // ==========================================
    // Reference model and checks.
    // ==========================================
    // New decisions while the clock is low: mid, top, bottom codes, then random.
    always @(negedge sclk)
    begin
        pat++;
        foreach (dec[i]) dec[i] = (pat < 3) ? 2'((pat + 1) % 3) : 2'({$random(seed)} % 3);
    end
    // A word leaves seven samples later; a stalled full buffer drops it.
    always @(posedge sclk)
    begin
        if (!shut)
        begin
            pipe_q.push_back(calc());
            if (pipe_q.size() > 7 && !(oe_n && exp_q.size() >= 4))
                exp_q.push_back(pipe_q.pop_front());
            else if (pipe_q.size() > 7)
                void'(pipe_q.pop_front());
        end
    end
    // Every strobed word is checked against the oldest expected one.
    always @(negedge MCLK)
    begin
        cycles++;
        if (cycles > 2000)
        begin
            failures++;
            end_sim();
        end
        else if (strobe === 1'b1)
        begin
            cmp("pending", 12'h001, 12'(exp_q.size() > 0));
            last_exp = exp_q.pop_front();
            cmp("word", 12'(last_exp), word);
            cmp("lines", 12'(last_exp), bus);
        end
    end
    // ==========================================
    // Main sequence.
    // ==========================================
    initial
    begin
        repeat (8) @(negedge MCLK);
        SRST <= 1'b0;
        periods(20);
        cmp("oe_on", 12'hfff, oe);
        oe_n <= 1'b1;
        repeat (8) @(negedge MCLK);
        cmp("oe_off", 12'h000, oe);
        periods(10);
        oe_n <= 1'b0;
        repeat (16) @(negedge MCLK);
        cmp("left", 12'h000, 12'(exp_q.size()));
        shut <= 1'b1;
        repeat (8) @(negedge MCLK);
        periods(5);
        cmp("shut", 12'h001, 12'(shut_act));
        cmp("frozen", 12'(last_exp), word);
        cmp("frozen_lines", 12'(last_exp), bus);
        shut <= 1'b0;
        repeat (8) @(negedge MCLK);
        periods(12);
        cmp("left", 12'h000, 12'(exp_q.size()));
        end_sim();
    end
endmodule
bind adc_output_port adc_output_port_checker adc_output_port_checker_b (.MCLK(MCLK),
    .SRST(SRST), .SAMPLE_CLK(SAMPLE_CLK), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
    .SHUTDOWN_REQUEST(SHUTDOWN_REQUEST), .SAMPLE_WORD_O(SAMPLE_WORD_O),
    .SAMPLE_WORD_OE(SAMPLE_WORD_OE), .WORD_STROBE(WORD_STROBE),
    .SHUTDOWN_ACTIVE(SHUTDOWN_ACTIVE));
